//--- common/dts_pkg.sv
package dts_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_CHAN = 3;
	localparam int CODE_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;

	// ----------------------------------------------------------------
	// trigger select codes handled by this block
	// ----------------------------------------------------------------
	localparam logic [3:0] CODE_MULT_READY = 4'hB;
	localparam logic [3:0] CODE_SERIAL_RX = 4'hC;
	localparam logic [3:0] CODE_SERIAL_TX = 4'hD;
	localparam logic [3:0] CODE_CHAIN_DONE = 4'hE;
	localparam logic [3:0] CODE_EXT_TRIG = 4'hF;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_TRIG_SEL = 8'h00;
	localparam logic [7:0] OFS_DONE = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_REQ_STATUS = 8'h10;

	localparam logic [11:0] TRIG_SEL_RESET = 12'h000;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_MULT,
		SRC_RX,
		SRC_TX,
		SRC_CHAIN,
		SRC_EXT
	} dts_src_type;

	function automatic dts_src_type decode_src(input logic [3:0] code);
		case (code)
			CODE_MULT_READY: decode_src = SRC_MULT;
			CODE_SERIAL_RX: decode_src = SRC_RX;
			CODE_SERIAL_TX: decode_src = SRC_TX;
			CODE_CHAIN_DONE: decode_src = SRC_CHAIN;
			CODE_EXT_TRIG: decode_src = SRC_EXT;
			default: decode_src = SRC_NONE;
		endcase
	endfunction

	function automatic logic addr_hit(input logic [7:0] addr);
		addr_hit = (addr == OFS_TRIG_SEL) || (addr == OFS_DONE) ||
			(addr == OFS_IRQ_STATUS) || (addr == OFS_IRQ_MASK) ||
			(addr == OFS_REQ_STATUS);
	endfunction

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

endpackage

//--- core/dts_axil_slave.sv
`timescale 1ns/1ps
module dts_axil_slave (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data
);

	logic aw_have;
	logic w_have;
	logic rd_pend;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic next_aw_have;
	logic next_w_have;
	logic next_bvalid;
	logic next_rvalid;

	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	// address and data may arrive in either order; commit once both are held
	assign wr_en = aw_have && w_have && !s_axi_bvalid;
	assign rd_en = rd_pend;
	assign next_aw_have = (aw_have || aw_hs) && !wr_en;
	assign next_w_have = (w_have || w_hs) && !wr_en;
	assign next_bvalid = wr_en || (s_axi_bvalid && !s_axi_bready);
	assign next_rvalid = rd_pend || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dts_pkg::RESP_OKAY;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			s_axi_awready <= !next_aw_have && !next_bvalid;
			s_axi_wready <= !next_w_have && !next_bvalid;
			s_axi_bvalid <= next_bvalid;
			if (wr_en) begin
				s_axi_bresp <= dts_pkg::addr_hit(wr_addr) ?
					dts_pkg::RESP_OKAY : dts_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else begin
			if (aw_hs) begin
				wr_addr <= s_axi_awaddr;
			end
			if (w_hs) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= dts_pkg::RESP_OKAY;
		end else begin
			rd_pend <= ar_hs;
			s_axi_arready <= !ar_hs && !next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (ar_hs) begin
				rd_addr <= s_axi_araddr;
			end
			if (rd_pend) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= dts_pkg::addr_hit(rd_addr) ?
					dts_pkg::RESP_OKAY : dts_pkg::RESP_SLVERR;
			end
		end
	end

endmodule

//--- core/dts_trig_chan.sv
`timescale 1ns/1ps
module dts_trig_chan (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// configuration
	input wire logic [3:0] trig_code,
	// trigger sources, already qualified
	input wire logic mult_ready,
	input wire logic serial_rx_go,
	input wire logic serial_tx_go,
	input wire logic chain_done,
	input wire logic ext_trig,
	// transfer engine
	input wire logic chan_start,
	output logic chan_request
);

	dts_pkg::dts_src_type src;
	logic level;
	logic level_prev;

	assign src = dts_pkg::decode_src(trig_code);

	always_comb begin
		case (src)
			dts_pkg::SRC_MULT: level = mult_ready;
			dts_pkg::SRC_RX: level = serial_rx_go;
			dts_pkg::SRC_TX: level = serial_tx_go;
			dts_pkg::SRC_CHAIN: level = chain_done;
			dts_pkg::SRC_EXT: level = ext_trig;
			default: level = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			level_prev <= 1'b0;
		end else begin
			level_prev <= level;
		end
	end

	// a rising source posts a request; a new edge in the start cycle wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_request <= 1'b0;
		end else if (level && !level_prev) begin
			chan_request <= 1'b1;
		end else if (chan_start) begin
			chan_request <= 1'b0;
		end
	end

	a_edge_posts: assert property (@(posedge core_clk) disable iff (rst)
		level && !level_prev |=> chan_request)
		else $error("source edge did not post a request");

	a_none_quiet: assert property (@(posedge core_clk) disable iff (rst)
		src == dts_pkg::SRC_NONE && !chan_request |=> !chan_request)
		else $error("unimplemented code raised a request");

endmodule

//--- core/dts_top.sv
`timescale 1ns/1ps
// How it works
// - tx flag set requests when tx selected
// - tx flag cleared when its transfer starts
// - tx irq enable blocks tx flag trigger
// - rx irq enable blocks rx flag trigger
// - done flags chain: 0 to 1, 1 to 2, 2 to 0
// - chained done flag stays set at start
// - code 1011 triggers on multiplier ready
// - code 1111 triggers on external pin
// - done flag set when size count hits zero
module dts_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// on-chip peripherals
	input wire logic serial_tx_flag,
	input wire logic serial_tx_irq_enable,
	input wire logic serial_rx_flag,
	input wire logic serial_rx_irq_enable,
	input wire logic mult_ready,
	output logic serial_tx_clear,
	output logic serial_rx_clear,
	// external trigger pin
	input wire logic ext_trigger_in,
	// transfer engine
	input wire logic [2:0] chan_start,
	input wire logic [2:0] count_zero,
	output logic [2:0] chan_request,
	output logic [2:0] chan_done_flag,
	// interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic [31:0] wmask;

	dts_axil_slave u_bus (
		.core_clk(core_clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	assign wmask = dts_pkg::strb_mask(wr_strb);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [11:0] trig_sel;
	logic [2:0] irq_mask;
	logic [2:0] irq_status;
	logic [2:0] done_wclr;
	logic wr_sel;
	logic wr_mask;
	logic wr_done;
	logic rd_status;

	assign wr_sel = wr_en && wr_addr == dts_pkg::OFS_TRIG_SEL;
	assign wr_mask = wr_en && wr_addr == dts_pkg::OFS_IRQ_MASK;
	assign wr_done = wr_en && wr_addr == dts_pkg::OFS_DONE;
	assign rd_status = rd_en && rd_addr == dts_pkg::OFS_IRQ_STATUS;
	// done flags are write-one-to-clear
	assign done_wclr = wr_done ? (wr_data[2:0] & wmask[2:0]) : 3'h0;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			trig_sel <= dts_pkg::TRIG_SEL_RESET;
		end else if (wr_sel) begin
			trig_sel <= (trig_sel & ~wmask[11:0]) | (wr_data[11:0] & wmask[11:0]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_mask <= dts_pkg::IRQ_MASK_RESET;
		end else if (wr_mask) begin
			irq_mask <= (irq_mask & ~wmask[2:0]) | (wr_data[2:0] & wmask[2:0]);
		end
	end

	always_comb begin
		rd_data = 32'h00000000;
		case (rd_addr)
			dts_pkg::OFS_TRIG_SEL: rd_data[11:0] = trig_sel;
			dts_pkg::OFS_DONE: rd_data[2:0] = chan_done_flag;
			dts_pkg::OFS_IRQ_STATUS: rd_data[2:0] = irq_status;
			dts_pkg::OFS_IRQ_MASK: rd_data[2:0] = irq_mask;
			dts_pkg::OFS_REQ_STATUS: rd_data[2:0] = chan_request;
			default: rd_data = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// trigger sources
	// ----------------------------------------------------------------
	logic ext_meta;
	logic ext_sync;
	logic serial_tx_go;
	logic serial_rx_go;

	// the pin is asynchronous; only the second stage is looked at
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= ext_trigger_in;
			ext_sync <= ext_meta;
		end
	end

	// an enabled serial interrupt keeps the flag for the cpu
	assign serial_tx_go = serial_tx_flag && !serial_tx_irq_enable;
	assign serial_rx_go = serial_rx_flag && !serial_rx_irq_enable;

	// ----------------------------------------------------------------
	// per-channel trigger logic and done flags
	// ----------------------------------------------------------------
	logic [2:0] start_tx;
	logic [2:0] start_rx;

	for (genvar i = 0; i < dts_pkg::NUM_CHAN; i++) begin : g_chan
		logic [3:0] code;
		dts_pkg::dts_src_type src;

		assign code = trig_sel[dts_pkg::CODE_W * i +: dts_pkg::CODE_W];
		assign src = dts_pkg::decode_src(code);
		assign start_tx[i] = chan_start[i] && src == dts_pkg::SRC_TX;
		assign start_rx[i] = chan_start[i] && src == dts_pkg::SRC_RX;

		// previous channel in the ring feeds this one
		dts_trig_chan u_chan (
			.core_clk(core_clk),
			.rst(rst),
			.trig_code(code),
			.mult_ready(mult_ready),
			.serial_rx_go(serial_rx_go),
			.serial_tx_go(serial_tx_go),
			.chain_done(chan_done_flag[(i + dts_pkg::NUM_CHAN - 1) %
				dts_pkg::NUM_CHAN]),
			.ext_trig(ext_sync),
			.chan_start(chan_start[i]),
			.chan_request(chan_request[i])
		);

		// a start never touches the flag; only software clears it
		always_ff @(posedge core_clk) begin
			if (rst) begin
				chan_done_flag[i] <= 1'b0;
			end else if (count_zero[i]) begin
				chan_done_flag[i] <= 1'b1;
			end else if (done_wclr[i]) begin
				chan_done_flag[i] <= 1'b0;
			end
		end

		a_done_sets: assert property (@(posedge core_clk) disable iff (rst)
			count_zero[i] |=> chan_done_flag[i])
			else $error("done flag not set at count zero");

		a_done_holds: assert property (@(posedge core_clk) disable iff (rst)
			chan_done_flag[i] && chan_start[i] && !done_wclr[i]
			|=> chan_done_flag[i] [*1])
			else $error("done flag dropped at transfer start");
	end

	// ----------------------------------------------------------------
	// source flag clearing
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			serial_tx_clear <= 1'b0;
			serial_rx_clear <= 1'b0;
		end else begin
			serial_tx_clear <= |start_tx;
			serial_rx_clear <= |start_rx;
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// reading status clears it, but an event in that cycle survives
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= (rd_status ? 3'h0 : irq_status) | count_zero;
		end
	end

	// one cycle behind the status bit so the pin comes from a flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_tx_trigger: assert property (@(posedge core_clk) disable iff (rst)
		$rose(serial_tx_flag) && !serial_tx_irq_enable &&
		g_chan[0].src == dts_pkg::SRC_TX && $stable(trig_sel)
		|=> chan_request[0])
		else $error("tx flag did not request channel 0");

	a_tx_clear: assert property (@(posedge core_clk) disable iff (rst)
		chan_start[0] && g_chan[0].src == dts_pkg::SRC_TX
		|=> serial_tx_clear ##1 (!serial_tx_clear || $past(|start_tx)))
		else $error("tx flag clear not pulsed on start");

	a_tx_blocked: assert property (@(posedge core_clk) disable iff (rst)
		serial_tx_irq_enable && g_chan[0].src == dts_pkg::SRC_TX &&
		!chan_request[0] |=> !chan_request[0])
		else $error("tx flag triggered while its irq enabled");

	a_rx_blocked: assert property (@(posedge core_clk) disable iff (rst)
		serial_rx_irq_enable && g_chan[0].src == dts_pkg::SRC_RX &&
		!chan_request[0] |=> !chan_request[0])
		else $error("rx flag triggered while its irq enabled");

	a_chain_wrap: assert property (@(posedge core_clk) disable iff (rst)
		$rose(chan_done_flag[2]) && g_chan[0].src == dts_pkg::SRC_CHAIN &&
		$stable(trig_sel) |=> chan_request[0])
		else $error("channel 2 done did not trigger channel 0");

	a_mult_trigger: assert property (@(posedge core_clk) disable iff (rst)
		$rose(mult_ready) && trig_sel[3:0] == dts_pkg::CODE_MULT_READY &&
		$stable(trig_sel) |=> chan_request[0])
		else $error("multiplier ready did not request");

	a_ext_trigger: assert property (@(posedge core_clk) disable iff (rst)
		$rose(ext_trigger_in) ##0
		(trig_sel[3:0] == dts_pkg::CODE_EXT_TRIG) [*3]
		|=> chan_request[0])
		else $error("external pin did not request in time");

	a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
		$past(|(irq_status & irq_mask)) |-> irq)
		else $error("irq low with unmasked status");

endmodule

//--- verification/dts_periph_model.sv
`timescale 1ns/1ps
module dts_periph_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// bench commands
	input wire logic set_tx,
	input wire logic set_rx,
	input wire logic mult_go,
	input wire logic ext_go,
	// clear requests from the block
	input wire logic serial_tx_clear,
	input wire logic serial_rx_clear,
	// peripheral side
	output logic serial_tx_flag,
	output logic serial_rx_flag,
	output logic mult_ready,
	output logic ext_trigger_in
);
	// flags stay set until the block clears them, like a real port
	always_ff @(posedge core_clk) begin
		if (rst) begin
			serial_tx_flag <= 1'b0;
			serial_rx_flag <= 1'b0;
		end else begin
			if (set_tx)
				serial_tx_flag <= 1'b1;
			else if (serial_tx_clear)
				serial_tx_flag <= 1'b0;
			if (set_rx)
				serial_rx_flag <= 1'b1;
			else if (serial_rx_clear)
				serial_rx_flag <= 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		mult_ready <= mult_go & ~rst;
		ext_trigger_in <= ext_go & ~rst;
	end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic tx_f, tx_en, rx_f, rx_en, mult, tx_clr, rx_clr, ext, g;
	logic set_tx, set_rx, mult_go, ext_go, irq;
	logic [2:0] chan_start, count_zero, chan_request, chan_done_flag;
	int errors, n_compared, seed, k;

	always #2.5 core_clk = ~core_clk;

	dts_top dut (.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .serial_tx_flag(tx_f),
		.serial_tx_irq_enable(tx_en), .serial_rx_flag(rx_f),
		.serial_rx_irq_enable(rx_en), .mult_ready(mult),
		.serial_tx_clear(tx_clr), .serial_rx_clear(rx_clr),
		.ext_trigger_in(ext), .chan_start(chan_start),
		.count_zero(count_zero), .chan_request(chan_request),
		.chan_done_flag(chan_done_flag), .irq(irq));

	dts_periph_model model (.core_clk(core_clk), .rst(rst),
		.set_tx(set_tx), .set_rx(set_rx), .mult_go(mult_go),
		.ext_go(ext_go), .serial_tx_clear(tx_clr),
		.serial_rx_clear(rx_clr), .serial_tx_flag(tx_f),
		.serial_rx_flag(rx_f), .mult_ready(mult), .ext_trigger_in(ext));

	task automatic test_done;
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// codes 0..A are not implemented by this block
	function automatic logic [3:0] rc();
		rc = 4'($unsigned($random(seed)) % 11);
	endfunction

	function automatic logic [2:0] nxt(input int c);
		nxt = 3'b001 << ((c + 1) % 3);
	endfunction

	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		int i;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 40) begin
			chk("bvalid", 1, 0);
			test_done;
		end
	endtask

	task automatic axr(input logic [7:0] a);
		int i;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 40) begin
			chk("rvalid", 1, 0);
			test_done;
		end
	endtask

	task automatic ss(input logic [11:0] c);
		axw(dts_pkg::OFS_TRIG_SEL, {20'h0, c});
		axr(dts_pkg::OFS_TRIG_SEL);
		chk("trig_sel", {20'h0, c}, d);
	endtask

	// collects every request seen over six cycles
	task automatic rq(input logic [2:0] e);
		logic [2:0] s;
		s = 3'b000;
		repeat (6) begin
			@(posedge core_clk);
			s = s | chan_request;
		end
		chk("chan_request", 32'(e), 32'(s));
	endtask

	// one-cycle pulse on count_zero (z) or chan_start, settled on return
	task automatic pl(input logic [2:0] v, input logic z);
		@(posedge core_clk);
		if (z)
			count_zero <= v;
		else
			chan_start <= v;
		@(posedge core_clk);
		count_zero <= 3'b000;
		chan_start <= 3'b000;
		#1;
	endtask

	task automatic flag(input int k);
		@(posedge core_clk);
		set_tx <= (k == 0);
		set_rx <= (k == 1);
		@(posedge core_clk);
		set_tx <= 1'b0;
		set_rx <= 1'b0;
	endtask

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, tx_en, rx_en} = '0;
		{set_tx, set_rx, mult_go, ext_go, chan_start, count_zero} = '0;
		s_axi_wstrb = 4'hF;
		errors = 0;
		n_compared = 0;
		seed = 32'h21B0EB16;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		axr(dts_pkg::OFS_TRIG_SEL);
		chk("trig_sel", 0, d);
		axr(dts_pkg::OFS_IRQ_MASK);
		chk("irq_mask", 0, d);
		axr(8'h14);
		chk("rresp", 2, r);
		chk("rdata", 0, d);
		axw(8'h14, 32'hFFFFFFFF);
		chk("bresp", 2, r);
		// random unimplemented codes with multiplier, external pin and done flag sources active
		for (k = 0; k < 4; k++) begin
			ss({rc(), rc(), rc()});
			@(posedge core_clk);
			mult_go <= 1'b1;
			ext_go <= 1'b1;
			pl(3'($random(seed)), 1);
			mult_go <= 1'b0;
			ext_go <= 1'b0;
			rq(3'b000);
		end
		axw(dts_pkg::OFS_DONE, 32'h7);
		// serial flags: k=0 transmit, k=1 receive
		for (k = 0; k < 2; k++) begin
			ss(k ? 12'h00C : 12'h00D);
			flag(k);
			rq(3'b001);
			pl(3'b001, 0);
			chk("flag_clear", 1, k ? rx_clr : tx_clr);
			chk("chan_request", 0, chan_request);
			repeat (2) @(posedge core_clk);
			chk("flag", 0, k ? rx_f : tx_f);
			tx_en <= 1'b1;
			rx_en <= k[0];
			flag(k);
			rq(3'b000);
		end
		ss(12'hEEE);
		for (k = 0; k < 3; k++) begin
			pl(3'b001 << k, 1);
			chk("done_flag", 1, chan_done_flag[k]);
			rq(nxt(k));
			pl(nxt(k), 0);
			chk("done_flag", 1, chan_done_flag[k]);
			chk("chan_request", 0, chan_request);
		end
		axr(dts_pkg::OFS_DONE);
		chk("done_reg", 7, d);
		axw(dts_pkg::OFS_DONE, 32'h7);
		chk("done_flag", 0, chan_done_flag);
		ss({8'h00, dts_pkg::CODE_MULT_READY});
		@(posedge core_clk);
		mult_go <= 1'b1;
		rq(3'b001);
		pl(3'b001, 0);
		rq(3'b000);
		mult_go <= 1'b0;
		ss(12'hFFF);
		@(posedge core_clk);
		ext_go <= 1'b1;
		@(posedge core_clk);
		ext_go <= 1'b0;
		rq(3'b111);
		axr(dts_pkg::OFS_REQ_STATUS);
		chk("req_status", 7, d);
		pl(3'b111, 0);
		// interrupt: masked event, unmasked event, clear on read
		axr(dts_pkg::OFS_IRQ_STATUS);
		axw(dts_pkg::OFS_IRQ_MASK, 32'h2);
		pl(3'b001, 1);
		repeat (3) @(posedge core_clk);
		chk("irq", 0, irq);
		pl(3'b010, 1);
		repeat (3) @(posedge core_clk);
		chk("irq", 1, irq);
		axr(dts_pkg::OFS_IRQ_STATUS);
		chk("irq_status", 3, d);
		repeat (3) @(posedge core_clk);
		chk("irq", 0, irq);
		test_done;
	end
endmodule
